// File: rtl/cdc_top.sv
// clock divisor control register with prescaler and clock-reduction guard
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ns

// Function
// - The phase detector input clock is divided by the prescale field plus two, from 2 at 00000 to 33 at 11111, with 00000 after reset.
// - A write to the clock-reduction ratio is dropped while the clock-reduction enable is set.
// - An attempt to set the clock-reduction enable is dropped whenever the ratio would be 000, leaving the enable clear.
// - Only the power-on reset returns the control register to its reset value; other resets leave it alone.
// - With restore-on-interrupt set, any interrupt clears the clock-reduction enable.
module cdc_top (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          sys_rst,
  input  wire logic                          irq_event,
  input  wire cdc_pkg::cdc_bus_req_t         bus_req,
  output logic [cdc_pkg::DATA_W-1:0]         rdata,
  output logic                               synth_pd_clk,
  output logic                               pd_boundary,
  output logic [cdc_pkg::RATIO_W-1:0]        cpu_clock_reduction_ratio,
  output logic                               cpu_clock_reduction_enable
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address match for a register offset
  function automatic logic hit(
    input logic [cdc_pkg::ADDR_W-1:0] a,
    input logic [cdc_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // image of the control register as software reads it
  function automatic logic [cdc_pkg::DATA_W-1:0] ctrl_image(
    input cdc_pkg::cdc_ctrl_t c);
    cdc_pkg::cdc_ctrl_t t;
    t        = c;
    t.unused = '0;
    ctrl_image = t;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cdc_pkg::cdc_ctrl_t          ctrl;
  cdc_pkg::cdc_ctrl_t          next_ctrl;
  cdc_pkg::cdc_sticky_t        sticky;
  cdc_pkg::cdc_sticky_t        next_sticky;
  logic [cdc_pkg::DATA_W-1:0]  next_rdata;
  logic [cdc_pkg::PRE_W-1:0]   applied_prescale;
  logic [cdc_pkg::RATIO_W-1:0] wr_ratio;
  logic [cdc_pkg::RATIO_W-1:0] eff_ratio;
  logic                        wr_ctrl;
  logic                        wr_stat;
  logic                        wr_en;
  logic                        ratio_drop;
  logic                        en_drop;
  logic                        irq_clear;
  logic [cdc_pkg::DATA_W-1:0]  stat_image;

  // ----------------------------------------------------------------
  // write decode and protection
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl  = bus_req.wr && hit(bus_req.addr, cdc_pkg::OFS_CTRL);
    wr_stat  = bus_req.wr && hit(bus_req.addr, cdc_pkg::OFS_STAT);
    wr_ratio = bus_req.wdata[cdc_pkg::RATIO_LSB +: cdc_pkg::RATIO_W];
    wr_en    = bus_req.wdata[cdc_pkg::EN_BIT];

    // ratio is frozen while reduction is enabled
    ratio_drop = wr_ctrl && ctrl.cpu_clock_reduction_enable
                 && (wr_ratio != ctrl.cpu_clock_reduction_ratio);
    eff_ratio  = ctrl.cpu_clock_reduction_enable ?
                 ctrl.cpu_clock_reduction_ratio : wr_ratio;

    // enable may not be set against a 000 ratio
    en_drop = wr_ctrl && wr_en && !ctrl.cpu_clock_reduction_enable
              && (eff_ratio == cdc_pkg::RATIO_NONE);

    // interrupt-driven clear of the enable
    irq_clear = irq_event && ctrl.restore_on_irq;
  end

  // ----------------------------------------------------------------
  // control register next value
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.synth_input_prescale =
        bus_req.wdata[cdc_pkg::PRE_LSB +: cdc_pkg::PRE_W];
      next_ctrl.restore_on_irq = bus_req.wdata[cdc_pkg::ROI_BIT];
      next_ctrl.cpu_clock_reduction_ratio = eff_ratio;
      next_ctrl.cpu_clock_reduction_enable =
        wr_en && (eff_ratio != cdc_pkg::RATIO_NONE);
    end
    // an interrupt in the same cycle as a software set still clears
    if (irq_clear) begin
      next_ctrl.cpu_clock_reduction_enable = 1'b0;
    end
    next_ctrl.unused = '0;
  end

  // ----------------------------------------------------------------
  // sticky status flags: hardware set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always_comb begin
    next_sticky = sticky;
    if (wr_stat) begin
      if (bus_req.wdata[cdc_pkg::ST_RATIO_REF]) begin
        next_sticky.ratio_refused = 1'b0;
      end
      if (bus_req.wdata[cdc_pkg::ST_EN_REF]) begin
        next_sticky.enable_refused = 1'b0;
      end
      if (bus_req.wdata[cdc_pkg::ST_IRQ_CLR]) begin
        next_sticky.irq_cleared = 1'b0;
      end
    end
    if (ratio_drop) begin
      next_sticky.ratio_refused = 1'b1;
    end
    if (en_drop) begin
      next_sticky.enable_refused = 1'b1;
    end
    if (irq_clear && ctrl.cpu_clock_reduction_enable) begin
      next_sticky.irq_cleared = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read path: data only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    stat_image = '0;
    stat_image[cdc_pkg::ST_PRE_LSB +: cdc_pkg::PRE_W] = applied_prescale;
    stat_image[cdc_pkg::ST_CLK_BIT]   = synth_pd_clk;
    stat_image[cdc_pkg::ST_RATIO_REF] = sticky.ratio_refused;
    stat_image[cdc_pkg::ST_EN_REF]    = sticky.enable_refused;
    stat_image[cdc_pkg::ST_IRQ_CLR]   = sticky.irq_cleared;
    next_rdata = '0;
    if (bus_req.rd) begin
      if (hit(bus_req.addr, cdc_pkg::OFS_CTRL)) begin
        next_rdata = ctrl_image(ctrl);
      end else if (hit(bus_req.addr, cdc_pkg::OFS_STAT)) begin
        next_rdata = stat_image;
      end else begin
        next_rdata = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers: only the power-on reset touches them
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl   <= cdc_pkg::cdc_ctrl_t'(cdc_pkg::CTRL_RESET);
      sticky <= cdc_pkg::cdc_sticky_t'(cdc_pkg::STICKY_RESET);
      rdata  <= '0;
    end else begin
      ctrl   <= next_ctrl;
      sticky <= next_sticky;
      rdata  <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs of the reduction fields
  // ----------------------------------------------------------------
  always_comb begin
    cpu_clock_reduction_ratio  = ctrl.cpu_clock_reduction_ratio;
    cpu_clock_reduction_enable = ctrl.cpu_clock_reduction_enable;
  end

  // ----------------------------------------------------------------
  // phase detector prescaler; other resets restart its count and load the pending prescale factor
  // ----------------------------------------------------------------
  cdc_prescaler u_prescaler (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .restart          (sys_rst),
    .prescale_factor  (ctrl.synth_input_prescale),
    .synth_pd_clk     (synth_pd_clk),
    .pd_boundary      (pd_boundary),
    .applied_prescale (applied_prescale)
  );

endmodule // cdc_top

// File: pkg/cdc_pkg.sv
// constants and carrier types for the clock divisor control block
package cdc_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned PRE_LSB   = 0;
  localparam int unsigned PRE_W     = 5;
  localparam int unsigned EN_BIT    = 11;
  localparam int unsigned RATIO_LSB = 12;
  localparam int unsigned RATIO_W   = 3;
  localparam int unsigned ROI_BIT   = 15;

  localparam logic [15:0]        CTRL_RESET  = 16'h0000;
  localparam logic [PRE_W-1:0]   PRE_RESET   = 5'h00;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 3'h0;
  localparam logic [RATIO_W-1:0] RATIO_NONE  = 3'h0;

  // divide ratio is prescale field plus this offset
  localparam logic [5:0] PRE_OFFSET = 6'h02;
  localparam int unsigned CNT_W     = 6;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_PRE_LSB     = 0;
  localparam int unsigned ST_CLK_BIT     = 5;
  localparam int unsigned ST_RATIO_REF   = 8;
  localparam int unsigned ST_EN_REF      = 9;
  localparam int unsigned ST_IRQ_CLR     = 10;
  localparam logic [2:0]  STICKY_RESET   = 3'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 restore_on_irq;
    logic [RATIO_W-1:0]   cpu_clock_reduction_ratio;
    logic                 cpu_clock_reduction_enable;
    logic [5:0]           unused;
    logic [PRE_W-1:0]     synth_input_prescale;
  } cdc_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cdc_bus_req_t;

  typedef struct packed {
    logic irq_cleared;
    logic enable_refused;
    logic ratio_refused;
  } cdc_sticky_t;

endpackage

// File: rtl/cdc_prescaler.sv
// glitch-free divider feeding the synthesiser phase detector
`timescale 1ns/1ns
module cdc_prescaler (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    restart,
  input  wire logic [cdc_pkg::PRE_W-1:0] prescale_factor,
  output logic                         synth_pd_clk,
  output logic                         pd_boundary,
  output logic [cdc_pkg::PRE_W-1:0]    applied_prescale
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last count of a period: divide ratio minus one
  function automatic logic [cdc_pkg::CNT_W-1:0] last_count(
    input logic [cdc_pkg::PRE_W-1:0] f);
    last_count = 6'({1'b0, f}) + cdc_pkg::PRE_OFFSET - 6'h01;
  endfunction

  // output stays high while the count is below half the ratio, rounded down
  function automatic logic [cdc_pkg::CNT_W-1:0] high_len(
    input logic [cdc_pkg::PRE_W-1:0] f);
    logic [cdc_pkg::CNT_W-1:0] d;
    d = 6'({1'b0, f}) + cdc_pkg::PRE_OFFSET;
    high_len = d >> 1;
  endfunction

  logic [cdc_pkg::CNT_W-1:0] cnt;
  logic [cdc_pkg::CNT_W-1:0] next_cnt;
  logic [cdc_pkg::PRE_W-1:0] next_applied;
  logic                      next_clk;
  logic                      next_boundary;
  logic                      at_last;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    at_last       = (cnt == last_count(applied_prescale));
    next_boundary = at_last;
    if (restart) begin
      next_cnt      = '0;
      next_applied  = prescale_factor;
      next_boundary = 1'b0;
    end else if (at_last) begin
      next_cnt     = '0;
      next_applied = prescale_factor;
    end else begin
      next_cnt     = cnt + 6'h01;
      next_applied = applied_prescale;
    end
    next_clk = (next_cnt < high_len(next_applied));
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt              <= '0;
      applied_prescale <= cdc_pkg::PRE_RESET;
      synth_pd_clk     <= 1'b1;
      pd_boundary      <= 1'b0;
    end else begin
      cnt              <= next_cnt;
      applied_prescale <= next_applied;
      synth_pd_clk     <= next_clk;
      pd_boundary      <= next_boundary;
    end
  end

endmodule // cdc_prescaler

// File: bench/cdc_monitor.sv
// port-level assertions for the clock divisor control block
`timescale 1ns/1ns
module cdc_monitor (
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire logic                        sys_rst,
  input wire logic                        irq_event,
  input wire cdc_pkg::cdc_bus_req_t       bus_req,
  input wire logic                        synth_pd_clk,
  input wire logic                        pd_boundary,
  input wire logic [cdc_pkg::RATIO_W-1:0] cpu_clock_reduction_ratio,
  input wire logic                        cpu_clock_reduction_enable
);
  wire       en = cpu_clock_reduction_enable;
  wire [2:0] ratio = cpu_clock_reduction_ratio;
  wire       ctrl_wr = bus_req.wr && (bus_req.addr == cdc_pkg::OFS_CTRL);
  logic      roi_q;

  // restore-on-irq as software last wrote it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) roi_q <= 1'b0;
    else if (ctrl_wr) roi_q <= bus_req.wdata[cdc_pkg::ROI_BIT];
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  ratio_lock_a: assert property (
    ctrl_wr && en |=> $stable(ratio)) else $error("ratio moved while enabled");
  ratio_load_a: assert property (
    ctrl_wr && !en |=> ratio == $past(bus_req.wdata[14:12]))
    else $error("ratio write lost while disabled");
  enable_guard_a: assert property (
    en |-> ratio != 3'h0) else $error("enable set with zero ratio");
  sysrst_keep_a: assert property (
    sys_rst && !ctrl_wr && !irq_event |=> $stable(ratio) && $stable(en))
    else $error("other reset altered control");
  por_clear_a: assert property (disable iff (1'b0)
    rst |-> ratio == 3'h0 && !en) else $error("control not cleared");
  irq_clear_a: assert property (
    irq_event && roi_q |=> !en) else $error("irq left enable set");
  div_period_a: assert property (disable iff (rst || sys_rst)
    pd_boundary |=> !pd_boundary ##[1:32] pd_boundary)
    else $error("divider period out of range");
  clk_align_a: assert property (
    $rose(synth_pd_clk) && !$past(sys_rst) |-> pd_boundary)
    else $error("divided clock rose off a boundary");
endmodule // cdc_monitor

bind cdc_top cdc_monitor u_cdc_monitor (
  .ref_clk(ref_clk), .rst(rst), .sys_rst(sys_rst), .irq_event(irq_event),
  .bus_req(bus_req), .synth_pd_clk(synth_pd_clk), .pd_boundary(pd_boundary),
  .cpu_clock_reduction_ratio(cpu_clock_reduction_ratio),
  .cpu_clock_reduction_enable(cpu_clock_reduction_enable));

// File: bench/test_clock_divisor_control.sv
// self-checking bench for the clock divisor control block
`timescale 1ns/1ns
module test_clock_divisor_control;
  localparam logic [3:0] CTRL = cdc_pkg::OFS_CTRL;
  logic                  ref_clk = 1'b0;
  logic                  rst = 1'b0;
  logic                  sys_rst = 1'b0;
  logic                  irq_event = 1'b0;
  cdc_pkg::cdc_bus_req_t bus_req = '0;
  logic [15:0]           rdata;
  logic [15:0]           d;
  logic [2:0]            ratio;
  logic                  en;
  logic                  pd_clk;
  logic                  bnd;
  int                    fails = 0;
  int                    cmp_count = 0;
  int                    n;
  int                    hi;

  always #50 ref_clk = ~ref_clk;

  cdc_top u_cdc_top (.ref_clk(ref_clk), .rst(rst), .sys_rst(sys_rst),
    .irq_event(irq_event), .bus_req(bus_req), .rdata(rdata),
    .synth_pd_clk(pd_clk), .pd_boundary(bnd),
    .cpu_clock_reduction_ratio(ratio), .cpu_clock_reduction_enable(en));

  task automatic check(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk) bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) bus_req <= '0;
    @(negedge ref_clk);
  endtask

  task automatic reg_rd(input logic [3:0] a);
    @(posedge ref_clk) bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) bus_req <= '0;
    @(negedge ref_clk) d = rdata;
  endtask

  // one-cycle pulse on the other reset or on the interrupt line
  task automatic pulse(input bit sel);
    @(posedge ref_clk) if (sel) sys_rst <= 1'b1; else irq_event <= 1'b1;
    @(posedge ref_clk) if (sel) sys_rst <= 1'b0; else irq_event <= 1'b0;
    @(negedge ref_clk);
  endtask

  // counts settled cycles up to the next boundary and the high ones in them
  task automatic wait_bnd(output int k, output int h);
    k = 0;
    h = 0;
    repeat (100) begin
      @(negedge ref_clk);
      k++;
      if (pd_clk === 1'b1) h++;
      if (bnd === 1'b1) return;
    end
    fails++;
    print_verdict();
  endtask

  task automatic t_divider();
    logic [4:0] pre [3] = '{5'h00, 5'h01, 5'h1f};
    foreach (pre[i]) begin
      reg_wr(CTRL, {11'h0, pre[i]});
      wait_bnd(n, hi);
      wait_bnd(n, hi);
      check("period", 16'(n), {11'h0, pre[i]} + 16'h2);
      check("high", 16'(hi), ({11'h0, pre[i]} + 16'h2) >> 1);
      reg_rd(cdc_pkg::OFS_STAT);
      check("applied", d & 16'h001f, {11'h0, pre[i]});
    end
  endtask

  task automatic t_guard();
    reg_wr(CTRL, 16'h0800);
    check("enable_zero_ratio", {15'h0, en}, 16'h0);
    reg_wr(CTRL, 16'h3800);
    check("ratio_taken", {13'h0, ratio}, 16'h3);
    reg_wr(CTRL, 16'h5800);
    reg_rd(CTRL);
    check("ratio_locked", d, 16'h3800);
    reg_rd(cdc_pkg::OFS_STAT);
    check("refusals", d & 16'h0700, 16'h0300);
    reg_wr(cdc_pkg::OFS_STAT, 16'h0300);
    reg_rd(cdc_pkg::OFS_STAT);
    check("refusals_clr", d & 16'h0700, 16'h0000);
  endtask

  task automatic t_irq();
    pulse(1'b0);
    check("enable_no_roi", {15'h0, en}, 16'h1);
    reg_wr(CTRL, 16'hb800);
    pulse(1'b0);
    check("enable_irq", {15'h0, en}, 16'h0);
    reg_rd(CTRL);
    check("enable_roi", d, 16'hb000);
    reg_rd(cdc_pkg::OFS_STAT);
    check("irq_flag", d & 16'h0400, 16'h0400);
  endtask

  task automatic t_reset();
    pulse(1'b1);
    reg_rd(CTRL);
    check("other_reset", d, 16'hb000);
    reg_wr(4'h8, 16'hffff);
    reg_rd(4'h8);
    check("unmapped", d, 16'h0000);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    reg_rd(CTRL);
    check("power_on", d, cdc_pkg::CTRL_RESET);
  endtask

  initial begin
    // a real rising edge so the asynchronous reset acts before the clock
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    reg_rd(CTRL);
    check("ctrl_reset", d, cdc_pkg::CTRL_RESET);
    t_divider();
    t_guard();
    t_irq();
    t_reset();
    print_verdict();
  end
endmodule // test_clock_divisor_control
